/* pkg/pscb_pkg.sv */
package pscb_pkg;
  // parameter bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int CMD_W = 16;

  // fieldbus parameter addresses
  localparam logic [15:0] ADDR_NV_BACKUP = 16'h0402;
  localparam logic [15:0] ADDR_CTRL_RESTORE = 16'h040e;
  localparam logic [15:0] ADDR_USER_DEFAULT = 16'h0410;
  localparam logic [15:0] ADDR_FACTORY_DEFAULT = 16'h0412;
  localparam logic [15:0] ADDR_SCALE_DIV = 16'h060e;
  localparam logic [15:0] ADDR_ROT_DIR = 16'h0618;

  // command field layout and trigger values
  localparam int CMD_GO_BIT = 0;
  localparam logic [15:0] CMD_ONE = 16'h0001;
  localparam logic [15:0] CMD_ZERO = 16'h0000;
  localparam logic [15:0] ROT_DIR_MAX = 16'h0001;

  // reset and default values of persistent parameters
  localparam logic RST_ROT_DIR = 1'b0;
  localparam logic [31:0] RST_SCALE_DIV = 32'h0000_4000;

  // non-volatile save duration
  localparam int CLK_MHZ = 40;
  localparam int NV_SAVE_TIME_US = 100;
  localparam int NV_SAVE_CYCLES = NV_SAVE_TIME_US * CLK_MHZ;

  // which save is running
  typedef enum logic [1:0] {OP_NONE, OP_BACKUP, OP_FACTORY} pscb_op_t;

  // backup and user reset trigger on bit 0 alone
  function automatic logic pscb_bit_go(input logic [15:0] v);
    return v[CMD_GO_BIT];
  endfunction
endpackage

/* hw/pscb_nv_seq.sv */
`timescale 1ns/100ps
// times one non-volatile save; busy spans the whole write, done ends it
module pscb_nv_seq
  import pscb_pkg::*;
#(
  parameter int SAVE_CYCLES = pscb_pkg::NV_SAVE_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(SAVE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(SAVE_CYCLES - 1);

  logic [CW-1:0] cnt; // cycles spent in the save
  logic [CW-1:0] next_cnt;
  logic next_busy;
  logic next_done;

  // start is ignored while busy; the caller refuses such writes anyway
  always_comb
  begin
    next_cnt = cnt;
    next_busy = busy;
    next_done = 1'b0;
    if (busy)
    begin
      if (cnt == LAST)
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_cnt = '0;
      end
      else
        next_cnt = cnt + CW'(1);
    end
    else if (start)
    begin
      next_busy = 1'b1;
      next_cnt = '0;
    end
  end

  // registers only
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      busy <= next_busy;
      done <= next_done;
    end
  end
endmodule

/* hw/pscb_scale_latch.sv */
`timescale 1ns/100ps
// holds the divisor that the position scaling really uses
module pscb_scale_latch
  import pscb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [31:0] value,
  output logic [31:0] active
);
  logic [31:0] next_active;

  // a stored divisor waits here until the ratio is adopted
  always_comb
  begin
    next_active = load ? value : active;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      active <= RST_SCALE_DIV;
    else
      active <= next_active;
  end
endmodule

/* hw/pscb_bank.sv */
`timescale 1ns/100ps
module pscb_bank
  import pscb_pkg::*;
#(
  parameter int SAVE_CYCLES = pscb_pkg::NV_SAVE_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [pscb_pkg::ADDR_W-1:0] par_addr,
  input wire logic par_wr,
  input wire logic [pscb_pkg::DATA_W-1:0] par_wdata,
  input wire logic par_rd,
  input wire logic restart,
  input wire logic scale_num_wr,
  output logic [pscb_pkg::DATA_W-1:0] par_rdata,
  output logic par_rvalid,
  output logic par_wack,
  output logic par_werr,
  output logic rot_dir_active,
  output logic [31:0] scale_div_active,
  output logic ctrl_tune_reset,
  output logic cur_loop_autoset,
  output logic nv_busy
);
  import pscb_pkg::*;

  // working copy of persistent parameters
  logic rot_dir;
  logic [31:0] scale_div;
  // non-volatile image, survives restart but not rstn
  logic nv_rot_dir;
  logic [31:0] nv_scale_div;
  // values captured when a save starts
  logic pend_rot_dir;
  logic [31:0] pend_div;
  pscb_op_t op;
  // command registers read back nonzero while their save runs
  logic [CMD_W-1:0] cmd_backup;
  logic [CMD_W-1:0] cmd_factory;
  logic nv_done;
  logic nv_start;
  logic latch_load;
  logic [31:0] latch_val;
  logic next_rot_dir;
  logic [31:0] next_scale_div;
  logic next_nv_rot_dir;
  logic [31:0] next_nv_scale_div;
  logic next_pend_rot_dir;
  logic [31:0] next_pend_div;
  pscb_op_t next_op;
  logic [CMD_W-1:0] next_cmd_backup;
  logic [CMD_W-1:0] next_cmd_factory;
  logic next_rot_dir_active;
  logic next_ctrl_tune_reset;
  logic next_cur_loop_autoset;
  logic next_wack;
  logic next_werr;
  logic [DATA_W-1:0] next_rdata;
  logic [CMD_W-1:0] wlo;

  assign wlo = par_wdata[CMD_W-1:0];
  // save timer; nv image is written only when it reports done
  pscb_nv_seq #(.SAVE_CYCLES(SAVE_CYCLES)) u_seq (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(nv_start),
    .busy(nv_busy),
    .done(nv_done)
  );

  // start-up reloads the ratio from nv, otherwise the numerator write adopts it
  assign latch_load = scale_num_wr | restart;
  assign latch_val = restart ? nv_scale_div : scale_div;

  pscb_scale_latch u_latch (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .load(latch_load),
    .value(latch_val),
    .active(scale_div_active)
  );

  // parameter writes, command launch, save completion and start-up
  always_comb
  begin
    next_rot_dir = rot_dir;
    next_scale_div = scale_div;
    next_nv_rot_dir = nv_rot_dir;
    next_nv_scale_div = nv_scale_div;
    next_pend_rot_dir = pend_rot_dir;
    next_pend_div = pend_div;
    next_op = op;
    next_cmd_backup = cmd_backup;
    next_cmd_factory = cmd_factory;
    next_rot_dir_active = rot_dir_active;
    next_ctrl_tune_reset = 1'b0;
    next_cur_loop_autoset = 1'b0;
    next_wack = 1'b0;
    next_werr = 1'b0;
    nv_start = 1'b0;
    // save finished: commit snapshot and let the command read zero
    if (nv_done)
    begin
      next_nv_rot_dir = pend_rot_dir;
      next_nv_scale_div = pend_div;
      next_cmd_backup = CMD_ZERO;
      next_cmd_factory = CMD_ZERO;
      next_op = OP_NONE;
    end
    // start-up: nv contents become the working and active state
    if (restart)
    begin
      next_rot_dir = nv_rot_dir;
      next_scale_div = nv_scale_div;
      next_rot_dir_active = nv_rot_dir;
    end
    else if (par_wr)
    begin
      next_wack = 1'b1;
      unique case (par_addr)
        ADDR_NV_BACKUP:
        begin
          // one save at a time; a second request while busy is refused
          if (nv_busy || nv_done)
          begin
            next_wack = 1'b0;
            next_werr = 1'b1;
          end
          else if (pscb_bit_go(wlo))
          begin
            next_cmd_backup = wlo;
            next_pend_rot_dir = rot_dir;
            next_pend_div = scale_div;
            next_op = OP_BACKUP;
            nv_start = 1'b1;
          end
        end
        ADDR_CTRL_RESTORE:
        begin
          if (wlo == CMD_ONE)
          begin
            next_ctrl_tune_reset = 1'b1;
            next_cur_loop_autoset = 1'b1;
          end
          else if (wlo != CMD_ZERO)
          begin
            next_wack = 1'b0;
            next_werr = 1'b1;
          end
        end
        ADDR_FACTORY_DEFAULT:
        begin
          if (nv_busy || nv_done)
          begin
            next_wack = 1'b0;
            next_werr = 1'b1;
          end
          else if (wlo == CMD_ONE)
          begin
            // defaults go to nv only; working state stays as it is
            next_cmd_factory = wlo;
            next_pend_rot_dir = RST_ROT_DIR;
            next_pend_div = RST_SCALE_DIV;
            next_op = OP_FACTORY;
            nv_start = 1'b1;
          end
        end
        ADDR_USER_DEFAULT:
        begin
          // working copy only, direction untouched, nv untouched
          if (pscb_bit_go(wlo))
            next_scale_div = RST_SCALE_DIV;
        end
        ADDR_SCALE_DIV:
        begin
          if ($signed(par_wdata) > 32'sh0000_0000)
            next_scale_div = par_wdata;
          else
          begin
            next_wack = 1'b0;
            next_werr = 1'b1;
          end
        end
        ADDR_ROT_DIR:
        begin
          // stored now, acts only after restart
          if (par_wdata[DATA_W-1:CMD_W] == 16'h0000 && wlo <= ROT_DIR_MAX)
            next_rot_dir = wlo[0];
          else
          begin
            next_wack = 1'b0;
            next_werr = 1'b1;
          end
        end
        default:
        begin
          next_wack = 1'b0;
          next_werr = 1'b1;
        end
      endcase
    end
  end

  // read mux; restore and user commands act at once so they read zero
  always_comb
  begin
    next_rdata = '0;
    unique case (par_addr)
      ADDR_NV_BACKUP: next_rdata = {16'h0000, cmd_backup};
      ADDR_FACTORY_DEFAULT: next_rdata = {16'h0000, cmd_factory};
      ADDR_SCALE_DIV: next_rdata = scale_div;
      ADDR_ROT_DIR: next_rdata = {31'h0000_0000, rot_dir};
      default: next_rdata = '0;
    endcase
  end

  // registers only
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      rot_dir <= RST_ROT_DIR;
      scale_div <= RST_SCALE_DIV;
      nv_rot_dir <= RST_ROT_DIR;
      nv_scale_div <= RST_SCALE_DIV;
      pend_rot_dir <= RST_ROT_DIR;
      pend_div <= RST_SCALE_DIV;
      op <= OP_NONE;
      cmd_backup <= CMD_ZERO;
      cmd_factory <= CMD_ZERO;
      rot_dir_active <= RST_ROT_DIR;
      ctrl_tune_reset <= 1'b0;
      cur_loop_autoset <= 1'b0;
      par_wack <= 1'b0;
      par_werr <= 1'b0;
      par_rdata <= '0;
      par_rvalid <= 1'b0;
    end
    else
    begin
      rot_dir <= next_rot_dir;
      scale_div <= next_scale_div;
      nv_rot_dir <= next_nv_rot_dir;
      nv_scale_div <= next_nv_scale_div;
      pend_rot_dir <= next_pend_rot_dir;
      pend_div <= next_pend_div;
      op <= next_op;
      cmd_backup <= next_cmd_backup;
      cmd_factory <= next_cmd_factory;
      rot_dir_active <= next_rot_dir_active;
      ctrl_tune_reset <= next_ctrl_tune_reset;
      cur_loop_autoset <= next_cur_loop_autoset;
      par_wack <= next_wack;
      par_werr <= next_werr;
      par_rdata <= par_rd ? next_rdata : par_rdata;
      par_rvalid <= par_rd;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_wr(logic [15:0] a);
    par_wr && !restart && par_addr == a;
  endsequence
  sequence s_backup_go;
    s_wr(ADDR_NV_BACKUP) and (wlo[0] && !nv_busy && !nv_done);
  endsequence
  sequence s_factory_go;
    s_wr(ADDR_FACTORY_DEFAULT) and (wlo == CMD_ONE && !nv_busy && !nv_done);
  endsequence
  sequence s_user_go;
    s_wr(ADDR_USER_DEFAULT) and (wlo[0]);
  endsequence
  property p_ctrl_restore;
    (s_wr(ADDR_CTRL_RESTORE) and (wlo == CMD_ONE)) |=> ctrl_tune_reset ##1 !ctrl_tune_reset;
  endproperty
  a_ctrl_restore: assert property (p_ctrl_restore) else $error("restore pulse missing");
  property p_autoset;
    ctrl_tune_reset |-> cur_loop_autoset;
  endproperty
  a_autoset: assert property (p_autoset) else $error("current loop not autoset");
  property p_backup_busy;
    s_backup_go |=> nv_busy && cmd_backup != CMD_ZERO;
  endproperty
  a_backup_busy: assert property (p_backup_busy) else $error("backup did not start");
  // done rises on the edge where busy falls and the commit lands one edge after that, so look a cycle later
  property p_save_ends_zero;
    $fell(nv_busy) |=> cmd_backup == CMD_ZERO && cmd_factory == CMD_ZERO;
  endproperty
  a_save_ends_zero: assert property (p_save_ends_zero) else $error("command not zero");
  property p_factory_nv;
    $fell(nv_busy) && $past(op) == OP_FACTORY |=> nv_scale_div == RST_SCALE_DIV;
  endproperty
  a_factory_nv: assert property (p_factory_nv) else $error("defaults not saved");
  property p_factory_keeps;
    s_factory_go |=> $stable(scale_div) && $stable(rot_dir);
  endproperty
  a_factory_keeps: assert property (p_factory_keeps) else $error("working state changed");
  property p_user_default;
    s_user_go |=> scale_div == RST_SCALE_DIV && $stable(rot_dir);
  endproperty
  a_user_default: assert property (p_user_default) else $error("user reset wrong");
  property p_user_no_nv;
    (s_user_go and (!nv_busy && !nv_done)) |=> $stable(nv_scale_div);
  endproperty
  a_user_no_nv: assert property (p_user_no_nv) else $error("user reset hit nv");
  property p_dir_late;
    !restart |=> $stable(rot_dir_active);
  endproperty
  a_dir_late: assert property (p_dir_late) else $error("direction changed early");
  property p_div_range;
    $signed(scale_div) > 32'sh0000_0000;
  endproperty
  a_div_range: assert property (p_div_range) else $error("divisor out of range");
  property p_ratio_adopt;
    !scale_num_wr && !restart |=> $stable(scale_div_active);
  endproperty
  a_ratio_adopt: assert property (p_ratio_adopt) else $error("ratio adopted early");
  property p_zero_noop;
    par_wr && !restart && par_wdata == 32'h0000_0000 && !nv_busy &&
      (par_addr == ADDR_NV_BACKUP || par_addr == ADDR_USER_DEFAULT) |=>
      !nv_busy && $stable(scale_div);
  endproperty
  a_zero_noop: assert property (p_zero_noop) else $error("zero started an operation");
endmodule

/* verification/pscb_master.sv */
`timescale 1ns/100ps
// fieldbus master: one strobed word per request, released lines go to the inverse value
module pscb_master
  import pscb_pkg::*;
(
  input wire logic sys_clk,
  output logic [pscb_pkg::ADDR_W-1:0] par_addr,
  output logic par_wr,
  output logic [pscb_pkg::DATA_W-1:0] par_wdata,
  output logic par_rd,
  input wire logic [pscb_pkg::DATA_W-1:0] par_rdata,
  input wire logic par_rvalid,
  input wire logic par_wack,
  input wire logic par_werr
);
  // idle bus at time zero
  initial
  begin
    par_addr = 16'h0000;
    par_wr = 1'b0;
    par_wdata = 32'h0000_0000;
    par_rd = 1'b0;
  end

  // one write: strobe for one cycle, answer sampled a cycle later
  task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic ack,
                    output logic err);
    @(negedge sys_clk);
    par_addr = a;
    par_wdata = d;
    par_wr = 1'b1;
    @(negedge sys_clk);
    par_wr = 1'b0;
    ack = par_wack;
    err = par_werr;
    // stale values would hide a design that samples late
    par_addr = ~a;
    par_wdata = ~d;
  endtask

  // one read: data and valid stand in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic v);
    @(negedge sys_clk);
    par_addr = a;
    par_rd = 1'b1;
    @(negedge sys_clk);
    par_rd = 1'b0;
    d = par_rdata;
    v = par_rvalid;
    par_addr = ~a;
  endtask
endmodule

/* verification/param_store_command_bank_tb.sv */
`timescale 1ns/100ps
module param_store_command_bank_tb;
  import pscb_pkg::*;
  localparam int SAVE = 8; // short save keeps the run brief
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic restart = 1'b0;
  logic scale_num_wr = 1'b0;
  logic [15:0] par_addr;
  logic par_wr;
  logic [31:0] par_wdata;
  logic par_rd;
  logic [31:0] par_rdata;
  logic par_rvalid;
  logic par_wack;
  logic par_werr;
  logic rot_dir_active;
  logic [31:0] scale_div_active;
  logic ctrl_tune_reset;
  logic cur_loop_autoset;
  logic nv_busy;
  int n_errors = 0;
  int num_checks = 0;

  // 40 MHz system clock
  always #12.5 sys_clk = ~sys_clk;

  pscb_bank #(.SAVE_CYCLES(SAVE)) pscb_bank_i (.sys_clk(sys_clk), .rstn(rstn),
    .par_addr(par_addr), .par_wr(par_wr), .par_wdata(par_wdata), .par_rd(par_rd),
    .restart(restart), .scale_num_wr(scale_num_wr), .par_rdata(par_rdata),
    .par_rvalid(par_rvalid), .par_wack(par_wack), .par_werr(par_werr),
    .rot_dir_active(rot_dir_active), .scale_div_active(scale_div_active),
    .ctrl_tune_reset(ctrl_tune_reset), .cur_loop_autoset(cur_loop_autoset),
    .nv_busy(nv_busy));

  pscb_master pscb_master_i (.sys_clk(sys_clk), .par_addr(par_addr), .par_wr(par_wr),
    .par_wdata(par_wdata), .par_rd(par_rd), .par_rdata(par_rdata),
    .par_rvalid(par_rvalid), .par_wack(par_wack), .par_werr(par_werr));

  // single verdict point
  task automatic conclude();
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // four-state compare so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // write and judge acceptance or refusal
  task automatic wr_exp(input logic [15:0] a, input logic [31:0] d, input logic ok);
    logic ack;
    logic err;
    pscb_master_i.wr(a, d, ack, err);
    chk({31'h0, ack}, {31'h0, ok}, "write ack");
    chk({31'h0, err}, {31'h0, ~ok}, "write refusal");
  endtask

  // read and judge the returned word
  task automatic rd_exp(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic v;
    pscb_master_i.rd(a, d, v);
    chk({31'h0, v}, 32'h1, "read valid");
    chk(d, exp, "read data");
  endtask

  // start-up pulse, active state checked the cycle after
  task automatic do_restart(input logic dir, input logic [31:0] div);
    @(negedge sys_clk);
    restart = 1'b1;
    @(negedge sys_clk);
    restart = 1'b0;
    chk({31'h0, rot_dir_active}, {31'h0, dir}, "direction in force");
    chk(scale_div_active, div, "divisor in force");
  endtask

  // bounded wait for the save to end
  task automatic wait_save();
    for (int i = 0; i < 4 * SAVE + 10; i++)
    begin
      @(negedge sys_clk);
      if (nv_busy === 1'b0)
        break;
    end
    chk({31'h0, nv_busy}, 32'h0, "save finished");
  endtask

  task automatic t_reset_values();
    rd_exp(ADDR_ROT_DIR, 32'h0);
    rd_exp(ADDR_SCALE_DIV, RST_SCALE_DIV);
    chk({31'h0, rot_dir_active}, 32'h0, "direction after reset");
  endtask

  task automatic t_ctrl_restore();
    wr_exp(ADDR_CTRL_RESTORE, 32'h1, 1'b1);
    chk({31'h0, ctrl_tune_reset}, 32'h1, "tuning reset pulse");
    chk({31'h0, cur_loop_autoset}, 32'h1, "current loop autoset");
    @(negedge sys_clk);
    chk({31'h0, ctrl_tune_reset | cur_loop_autoset}, 32'h0, "pulse ends");
    rd_exp(ADDR_CTRL_RESTORE, 32'h0);
    wr_exp(ADDR_CTRL_RESTORE, 32'h2, 1'b0);
  endtask

  task automatic t_divisor();
    wr_exp(ADDR_SCALE_DIV, 32'h0, 1'b0);
    wr_exp(ADDR_SCALE_DIV, 32'h8000_0000, 1'b0);
    wr_exp(ADDR_SCALE_DIV, 32'h1, 1'b1);
    wr_exp(ADDR_SCALE_DIV, 32'h7fff_ffff, 1'b1);
    rd_exp(ADDR_SCALE_DIV, 32'h7fff_ffff);
    chk(scale_div_active, RST_SCALE_DIV, "divisor not adopted yet");
    @(negedge sys_clk);
    scale_num_wr = 1'b1;
    @(negedge sys_clk);
    scale_num_wr = 1'b0;
    chk(scale_div_active, 32'h7fff_ffff, "divisor adopted");
  endtask

  task automatic t_direction_backup();
    wr_exp(ADDR_ROT_DIR, 32'h2, 1'b0);
    wr_exp(ADDR_ROT_DIR, 32'h1, 1'b1);
    rd_exp(ADDR_ROT_DIR, 32'h1);
    chk({31'h0, rot_dir_active}, 32'h0, "direction waits");
    // nothing saved yet, so start-up brings back the stored defaults
    do_restart(1'b0, RST_SCALE_DIV);
    wr_exp(ADDR_ROT_DIR, 32'h1, 1'b1);
    wr_exp(ADDR_SCALE_DIV, 32'h7fff_ffff, 1'b1);
    wr_exp(ADDR_NV_BACKUP, 32'h3, 1'b1);
    chk({31'h0, nv_busy}, 32'h1, "save running");
    wr_exp(ADDR_NV_BACKUP, 32'h1, 1'b0);
    // the written word stands in the command until the save ends
    rd_exp(ADDR_NV_BACKUP, 32'h3);
    wait_save();
    rd_exp(ADDR_NV_BACKUP, 32'h0);
    do_restart(1'b1, 32'h7fff_ffff);
  endtask

  task automatic t_user_reset();
    wr_exp(ADDR_SCALE_DIV, 32'h5, 1'b1);
    wr_exp(ADDR_USER_DEFAULT, 32'h1, 1'b1);
    chk({31'h0, nv_busy}, 32'h0, "no save on user reset");
    rd_exp(ADDR_SCALE_DIV, RST_SCALE_DIV);
    rd_exp(ADDR_ROT_DIR, 32'h1);
    rd_exp(ADDR_USER_DEFAULT, 32'h0);
    do_restart(1'b1, 32'h7fff_ffff);
    rd_exp(ADDR_SCALE_DIV, 32'h7fff_ffff);
  endtask

  task automatic t_factory();
    wr_exp(ADDR_FACTORY_DEFAULT, 32'h1, 1'b1);
    chk({31'h0, nv_busy}, 32'h1, "factory save running");
    rd_exp(ADDR_FACTORY_DEFAULT, 32'h1);
    wait_save();
    rd_exp(ADDR_FACTORY_DEFAULT, 32'h0);
    rd_exp(ADDR_ROT_DIR, 32'h1);
    rd_exp(ADDR_SCALE_DIV, 32'h7fff_ffff);
    do_restart(1'b0, RST_SCALE_DIV);
    rd_exp(ADDR_ROT_DIR, 32'h0);
  endtask

  // zero commands are acked and change nothing; unmapped places are refused
  task automatic t_zero_unmapped();
    logic [15:0] cmds [4];
    cmds = '{ADDR_NV_BACKUP, ADDR_CTRL_RESTORE, ADDR_USER_DEFAULT, ADDR_FACTORY_DEFAULT};
    wr_exp(ADDR_SCALE_DIV, 32'h9, 1'b1);
    foreach (cmds[i])
    begin
      wr_exp(cmds[i], 32'h0, 1'b1);
      chk({31'h0, nv_busy | ctrl_tune_reset}, 32'h0, "zero starts nothing");
    end
    wr_exp(ADDR_FACTORY_DEFAULT, 32'h2, 1'b1);
    chk({31'h0, nv_busy}, 32'h0, "factory two starts nothing");
    rd_exp(ADDR_SCALE_DIV, 32'h9);
    wr_exp(16'h0400, 32'h1, 1'b0);
    rd_exp(16'h0400, 32'h0);
  endtask

  // watchdog: the tests need well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end

  // main sequence: reset held 20 cycles, then each scenario
  initial
  begin
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    t_reset_values();
    t_ctrl_restore();
    t_divisor();
    t_direction_backup();
    t_user_reset();
    t_factory();
    t_zero_unmapped();
    conclude();
  end
endmodule
